// >>> inc/epo_regs.svh
`ifndef EPO_REGS_SVH
`define EPO_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define EPO_IDX_MODE_A 8'h0B
`define EPO_IDX_MODE_B 8'h0C
`define EPO_IDX_NL_MODE 8'h0E
`define EPO_IDX_EN_LOW 8'hD9
`define EPO_IDX_EN_MID 8'hDA
`define EPO_IDX_EN_HIGH 8'hDB
`define EPO_IDX_ST_LOW 8'hDC
`define EPO_IDX_ST_MID 8'hDD
`define EPO_IDX_ST_HIGH 8'hDE
`define EPO_IDX_PM_EN 8'hEC
`define EPO_IDX_NUM_A 8'h40
`define EPO_IDX_DEN_A 8'h41
`define EPO_IDX_NUM_B 8'h42
`define EPO_IDX_DEN_B 8'h43

// ****************************************************************
// Field positions
// ****************************************************************
`define EPO_MODEA_DIS_A 4
`define EPO_MODEA_DIS_B 5
`define EPO_MODEB_SRC_A 0
`define EPO_MODEB_SRC_B 2
`define EPO_MODEB_RMS_SEL 4
`define EPO_NL_FIELD 4
`define EPO_STL_CREEP 2
`define EPO_STM_PULSE_A 6
`define EPO_STM_PULSE_B 7
`define EPO_PM_AUTOCLR 6

// ****************************************************************
// Reset values
// ****************************************************************
`define EPO_RST_BYTE 8'h00
`define EPO_RST_RATIO 16'h0000

// ****************************************************************
// Timing and thresholds
// ****************************************************************
`define EPO_CLK_HZ 10000000
`define EPO_HOLD_MS 90
`define EPO_LONG_MS 180
`define EPO_NL_PPM_030 300
`define EPO_NL_PPM_015 150
`define EPO_NL_PPM_0075 75
`define EPO_PPM_DIV 1000000
`define EPO_FULL_SCALE 24'h40_0000

`endif

// >>> inc/epo_pkg.sv
`default_nettype none

package epo_pkg;
	// Wishbone classic request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} epo_wb_req_t;

	// One-cycle LSB increments of each energy source
	typedef struct packed {
		logic active;
		logic reactive;
		logic apparent;
		logic rms;
	} epo_energy_inc_t;

	typedef enum logic [1:0] {
		SRC_ACTIVE = 2'b00,
		SRC_REACTIVE = 2'b01,
		SRC_APP_RMS = 2'b10,
		SRC_APP_RMS_ALT = 2'b11
	} epo_src_t;

	typedef enum logic [1:0] {
		NL_OFF = 2'b00,
		NL_030 = 2'b01,
		NL_015 = 2'b10,
		NL_0075 = 2'b11
	} epo_nl_t;

	typedef enum logic {
		SHP_IDLE = 1'b0,
		SHP_LOW = 1'b1
	} epo_shape_t;
endpackage

`default_nettype wire

// >>> hw/epo_top.sv
// The Wishbone register port was chosen for this implementation.
`default_nettype none
`include "epo_regs.svh"

module epo_top #(
	parameter logic [20:0] HOLD_CYC = 21'(`EPO_CLK_HZ / 1000 * `EPO_HOLD_MS),
	parameter logic [20:0] LONG_CYC = 21'(`EPO_CLK_HZ / 1000 * `EPO_LONG_MS),
	parameter logic [23:0] FULL_SCALE = `EPO_FULL_SCALE
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Wishbone slave
	input wire epo_pkg::epo_wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Energy datapath
	input wire epo_pkg::epo_energy_inc_t energy_inc,
	input wire logic [23:0] apparent_power_mag,
	input wire logic [23:0] rms_current_mag,
	input wire logic [7:0] other_status_low,
	input wire logic [7:0] other_status_mid,
	input wire logic [7:0] other_status_high,
	output logic apparent_accum_en,
	// Calibration pulses and interrupt
	output logic pulse_out_a_n,
	output logic pulse_out_b_n,
	output logic energy_irq
);

	// ****************************************************************
	// Functions
	// ****************************************************************

	// No-load threshold as a share of multiplier full scale
	function automatic logic [23:0] nl_thr(input epo_pkg::epo_nl_t mode);
		logic [47:0] p;
		p = 48'h0000_0000_0000;
		unique case (mode)
			epo_pkg::NL_OFF: p = 48'h0000_0000_0000;
			epo_pkg::NL_030: p = 48'(FULL_SCALE) * 48'(`EPO_NL_PPM_030);
			epo_pkg::NL_015: p = 48'(FULL_SCALE) * 48'(`EPO_NL_PPM_015);
			epo_pkg::NL_0075: p = 48'(FULL_SCALE) * 48'(`EPO_NL_PPM_0075);
		endcase
		return 24'(p / 48'(`EPO_PPM_DIV));
	endfunction

	// Zero reads as one, ratio above one clamps to one
	function automatic logic [31:0] eff_ratio(input logic [15:0] n, input logic [15:0] d);
		logic [15:0] ne;
		logic [15:0] de;
		ne = (n == 16'h0000) ? 16'h0001 : n;
		de = (d == 16'h0000) ? 16'h0001 : d;
		if (ne > de) begin
			ne = de;
		end
		return {ne, de};
	endfunction

	// Status update: hardware set always beats a software clear
	function automatic logic [7:0] st_upd(input logic [7:0] old, input logic [7:0] set,
			input logic wr_hit, input logic [7:0] wdat, input logic rd_hit,
			input logic [7:0] rd_mask, input logic autoclr);
		logic [7:0] n;
		n = old;
		if (wr_hit && !autoclr) begin
			n = old & wdat;
		end
		if (rd_hit && autoclr) begin
			n = old & ~rd_mask;
		end
		return n | set;
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] mode_a_reg;
	logic [7:0] mode_b_reg;
	logic [7:0] nl_mode_reg;
	logic [7:0] en_low_reg;
	logic [7:0] en_mid_reg;
	logic [7:0] en_high_reg;
	logic [7:0] pm_en_reg;
	logic [7:0] st_low_reg;
	logic [7:0] st_mid_reg;
	logic [7:0] st_high_reg;
	logic [15:0] num_reg [2];
	logic [15:0] den_reg [2];
	logic ack_reg;
	logic [31:0] dat_reg;
	logic irq_reg;
	logic accum_en_reg;
	logic [1:0] out_n_reg;

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	logic req;
	logic [7:0] idx;
	logic in_range;
	logic wr_fire;
	logic rd_fire;
	logic autoclr;
	logic [7:0] wdat;
	logic [7:0] rdata;

	// Ack one cycle after the request; effects land on the ack edge
	assign req = wb_req.cyc & wb_req.stb;
	assign idx = wb_req.adr[9:2];
	assign in_range = (wb_req.adr[31:10] == 22'h00_0000) && (wb_req.adr[1:0] == 2'b00);
	assign wr_fire = req & ack_reg & wb_req.we & wb_req.sel[0] & in_range;
	assign rd_fire = req & ack_reg & ~wb_req.we & in_range;
	assign wdat = wb_req.dat[7:0];
	assign autoclr = pm_en_reg[`EPO_PM_AUTOCLR];
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// Read mux; unmapped indices read as zero
	always_comb begin
		rdata = 8'h00;
		if (in_range) begin
			unique case (idx)
				`EPO_IDX_MODE_A: rdata = mode_a_reg;
				`EPO_IDX_MODE_B: rdata = mode_b_reg;
				`EPO_IDX_NL_MODE: rdata = nl_mode_reg;
				`EPO_IDX_EN_LOW: rdata = en_low_reg;
				`EPO_IDX_EN_MID: rdata = en_mid_reg;
				`EPO_IDX_EN_HIGH: rdata = en_high_reg;
				`EPO_IDX_ST_LOW: rdata = st_low_reg;
				`EPO_IDX_ST_MID: rdata = st_mid_reg;
				`EPO_IDX_ST_HIGH: rdata = st_high_reg;
				`EPO_IDX_PM_EN: rdata = pm_en_reg;
				default: rdata = 8'h00;
			endcase
		end
	end

	// Handshake and captured read data
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req && !ack_reg) begin
				dat_reg <= {24'h00_0000, rdata};
				if (in_range && idx inside {`EPO_IDX_NUM_A, `EPO_IDX_NUM_B}) begin
					dat_reg <= {16'h0000, num_reg[idx[1]]};
				end
				if (in_range && idx inside {`EPO_IDX_DEN_A, `EPO_IDX_DEN_B}) begin
					dat_reg <= {16'h0000, den_reg[idx[1]]};
				end
			end
		end
	end

	// Plain control registers; ratio registers take two byte lanes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode_a_reg <= `EPO_RST_BYTE;
			mode_b_reg <= `EPO_RST_BYTE;
			nl_mode_reg <= `EPO_RST_BYTE;
			en_low_reg <= `EPO_RST_BYTE;
			en_mid_reg <= `EPO_RST_BYTE;
			en_high_reg <= `EPO_RST_BYTE;
			pm_en_reg <= `EPO_RST_BYTE;
			num_reg <= '{`EPO_RST_RATIO, `EPO_RST_RATIO};
			den_reg <= '{`EPO_RST_RATIO, `EPO_RST_RATIO};
		end else if (req && ack_reg && wb_req.we && in_range) begin
			if (wb_req.sel[0]) begin
				unique case (idx)
					`EPO_IDX_MODE_A: mode_a_reg <= wdat;
					`EPO_IDX_MODE_B: mode_b_reg <= wdat;
					`EPO_IDX_NL_MODE: nl_mode_reg <= wdat;
					`EPO_IDX_EN_LOW: en_low_reg <= wdat;
					`EPO_IDX_EN_MID: en_mid_reg <= wdat;
					`EPO_IDX_EN_HIGH: en_high_reg <= wdat;
					`EPO_IDX_PM_EN: pm_en_reg <= wdat;
					`EPO_IDX_NUM_A, `EPO_IDX_NUM_B: num_reg[idx[1]][7:0] <= wdat;
					`EPO_IDX_DEN_A, `EPO_IDX_DEN_B: den_reg[idx[1]][7:0] <= wdat;
					default: ;
				endcase
			end
			if (wb_req.sel[1] && idx inside {`EPO_IDX_NUM_A, `EPO_IDX_NUM_B}) begin
				num_reg[idx[1]][15:8] <= wb_req.dat[15:8];
			end
			if (wb_req.sel[1] && idx inside {`EPO_IDX_DEN_A, `EPO_IDX_DEN_B}) begin
				den_reg[idx[1]][15:8] <= wb_req.dat[15:8];
			end
		end
	end

	// ****************************************************************
	// No-load detection
	// ****************************************************************
	epo_pkg::epo_nl_t nl_sel;
	logic [23:0] thr;
	logic app_below;
	logic rms_below;

	assign nl_sel = epo_pkg::epo_nl_t'(nl_mode_reg[`EPO_NL_FIELD +: 2]);
	assign thr = nl_thr(nl_sel);
	assign app_below = (nl_sel != epo_pkg::NL_OFF) && (apparent_power_mag < thr);
	assign rms_below = (nl_sel != epo_pkg::NL_OFF) && (rms_current_mag < thr);
	assign apparent_accum_en = accum_en_reg;

	// Accumulator gate registered so the datapath sees a clean level
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			accum_en_reg <= 1'b1;
		end else begin
			accum_en_reg <= ~app_below;
		end
	end

	// ****************************************************************
	// Energy-to-frequency converters
	// ****************************************************************
	logic [15:0] acc_reg [2];
	logic [20:0] since_reg [2];
	logic [20:0] low_cnt_reg [2];
	epo_pkg::epo_shape_t shp_reg [2];
	logic [1:0] tick;
	logic [1:0] fire;
	logic [1:0] dis;
	logic [15:0] n_eff [2];
	logic [15:0] d_eff [2];
	logic [16:0] sum [2];
	logic [1:0] src [2];

	assign dis = {mode_a_reg[`EPO_MODEA_DIS_B], mode_a_reg[`EPO_MODEA_DIS_A]};
	assign src[0] = mode_b_reg[`EPO_MODEB_SRC_A +: 2];
	assign src[1] = mode_b_reg[`EPO_MODEB_SRC_B +: 2];

	// Source pick and ratio accumulation per channel
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			unique case (epo_pkg::epo_src_t'(src[i]))
				epo_pkg::SRC_ACTIVE: tick[i] = energy_inc.active;
				epo_pkg::SRC_REACTIVE: tick[i] = energy_inc.reactive;
				default: tick[i] = mode_b_reg[`EPO_MODEB_RMS_SEL] ?
					(energy_inc.rms & ~rms_below) : energy_inc.apparent;
			endcase
			{n_eff[i], d_eff[i]} = eff_ratio(num_reg[i], den_reg[i]);
			sum[i] = {1'b0, acc_reg[i]} + {1'b0, n_eff[i]};
			fire[i] = tick[i] & (sum[i] >= {1'b0, d_eff[i]}) & ~dis[i];
		end
	end

	// Ratio accumulator: one internal pulse per d_eff/n_eff energy LSBs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			acc_reg <= '{16'h0000, 16'h0000};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (tick[i]) begin
					if (sum[i] >= {1'b0, d_eff[i]}) begin
						acc_reg[i] <= 16'(sum[i] - {1'b0, d_eff[i]});
					end else begin
						acc_reg[i] <= sum[i][15:0];
					end
				end
			end
		end
	end

	// Pulse shaper; first pulse after reset is treated as a long period
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			since_reg <= '{21'h1F_FFFF, 21'h1F_FFFF};
			low_cnt_reg <= '{21'h00_0000, 21'h00_0000};
			shp_reg <= '{epo_pkg::SHP_IDLE, epo_pkg::SHP_IDLE};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (since_reg[i] != 21'h1F_FFFF) begin
					since_reg[i] <= since_reg[i] + 21'h00_0001;
				end
				unique case (shp_reg[i])
					epo_pkg::SHP_IDLE: ;
					epo_pkg::SHP_LOW: begin
						if (low_cnt_reg[i] <= 21'h00_0001) begin
							shp_reg[i] <= epo_pkg::SHP_IDLE;
						end
						low_cnt_reg[i] <= low_cnt_reg[i] - 21'h00_0001;
					end
				endcase
				if (fire[i]) begin
					since_reg[i] <= 21'h00_0000;
					shp_reg[i] <= epo_pkg::SHP_LOW;
					if (since_reg[i] > LONG_CYC) begin
						low_cnt_reg[i] <= HOLD_CYC;
					end else if (since_reg[i] > 21'h00_0001) begin
						// Counter lags the period by one, so add it back before halving
						low_cnt_reg[i] <= (since_reg[i] + 21'h00_0001) >> 1;
					end else begin
						low_cnt_reg[i] <= 21'h00_0001;
					end
				end
			end
		end
	end

	// Active-low outputs; a disabled output idles high
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			out_n_reg <= 2'b11;
		end else begin
			for (int i = 0; i < 2; i++) begin
				out_n_reg[i] <= dis[i] | ~(fire[i] |
					(shp_reg[i] == epo_pkg::SHP_LOW && low_cnt_reg[i] > 21'h00_0001));
			end
		end
	end
	assign pulse_out_a_n = out_n_reg[0];
	assign pulse_out_b_n = out_n_reg[1];

	// ****************************************************************
	// Status and interrupt
	// ****************************************************************
	logic [7:0] set_low;
	logic [7:0] set_mid;
	logic [7:0] rd_mask;

	// Only bits returned by the read are cleared, so late events survive
	assign rd_mask = dat_reg[7:0];
	assign set_low = other_status_low | (8'(app_below) << `EPO_STL_CREEP);
	assign set_mid = other_status_mid | (8'(fire[0]) << `EPO_STM_PULSE_A) |
		(8'(fire[1]) << `EPO_STM_PULSE_B);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_low_reg <= `EPO_RST_BYTE;
			st_mid_reg <= `EPO_RST_BYTE;
			st_high_reg <= `EPO_RST_BYTE;
		end else begin
			st_low_reg <= st_upd(st_low_reg, set_low, wr_fire && idx == `EPO_IDX_ST_LOW,
				wdat, rd_fire && idx == `EPO_IDX_ST_LOW, rd_mask, autoclr);
			st_mid_reg <= st_upd(st_mid_reg, set_mid, wr_fire && idx == `EPO_IDX_ST_MID,
				wdat, rd_fire && idx == `EPO_IDX_ST_MID, rd_mask, autoclr);
			st_high_reg <= st_upd(st_high_reg, other_status_high,
				wr_fire && idx == `EPO_IDX_ST_HIGH, wdat,
				rd_fire && idx == `EPO_IDX_ST_HIGH, rd_mask, autoclr);
		end
	end

	// Level interrupt, one cycle behind the status bits
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |((st_low_reg & en_low_reg) | (st_mid_reg & en_mid_reg) |
				(st_high_reg & en_high_reg));
		end
	end
	assign energy_irq = irq_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_accum_gate: assert property ((nl_sel != epo_pkg::NL_OFF && apparent_power_mag < thr)
		|=> !apparent_accum_en) else $error("accumulation not stopped below threshold");
	a_creep_flag: assert property (app_below |=> st_low_reg[`EPO_STL_CREEP])
		else $error("creep status not set");
	a_nl_off: assert property (nl_sel == epo_pkg::NL_OFF |-> !app_below)
		else $error("no-load detection active while off");
	a_pulse_flag: assert property (fire[0] |=> st_mid_reg[`EPO_STM_PULSE_A])
		else $error("pulse flag a not set");
	a_disable_high: assert property (dis[0] |=> pulse_out_a_n)
		else $error("disabled output driven low");
	a_ratio_clamp: assert property (n_eff[0] != 16'h0000 && n_eff[0] <= d_eff[0])
		else $error("effective ratio out of range");
	a_hold_len: assert property (fire[0] && since_reg[0] > LONG_CYC
		|=> low_cnt_reg[0] == HOLD_CYC && !pulse_out_a_n) else $error("long hold wrong");
	a_irq_masked: assert property (((st_low_reg & en_low_reg) | (st_mid_reg & en_mid_reg) |
		(st_high_reg & en_high_reg)) == 8'h00 |=> !energy_irq)
		else $error("interrupt without enabled status");
	a_irq_holds: assert property ((st_mid_reg & en_mid_reg) != 8'h00 [*2] |-> energy_irq)
		else $error("interrupt dropped while status set");
	a_auto_clear: assert property (rd_fire && autoclr && idx == `EPO_IDX_ST_MID &&
		set_mid == 8'h00 |=> (st_mid_reg & $past(rd_mask)) == 8'h00)
		else $error("auto clear on read failed");
	a_read_keeps: assert property (rd_fire && !autoclr && idx == `EPO_IDX_ST_MID
		|=> (st_mid_reg & $past(st_mid_reg)) == $past(st_mid_reg))
		else $error("read changed status without auto clear");

endmodule // epo_top

`default_nettype wire

// >>> tb/epo_cal_monitor.sv
`default_nettype none

// ****
// Calibration equipment on one optical pulse line
// ****
module epo_cal_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Optical pulse line, LED lit while low
	input wire logic pulse_n,
	// Observations
	output logic [7:0] pulse_cnt,
	output logic [7:0] low_width
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_reg;
	logic [7:0] run_reg;

	// Count falling edges and time each low phase
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prev_reg <= 1'b1;
			run_reg <= 8'h00;
			pulse_cnt <= 8'h00;
			low_width <= 8'h00;
		end else begin
			prev_reg <= pulse_n;
			if (prev_reg && !pulse_n) begin
				pulse_cnt <= pulse_cnt + 8'h01;
			end
			// Width latched only on release, so a stuck-low line keeps showing the previous width
			if (!pulse_n) begin
				run_reg <= run_reg + 8'h01;
			end else if (run_reg != 8'h00) begin
				low_width <= run_reg;
				run_reg <= 8'h00;
			end
		end
	end
endmodule // epo_cal_monitor

`default_nettype wire

// >>> tb/test_energy_pulse_output_and_irq.sv
`default_nettype none
`include "epo_regs.svh"

module test_energy_pulse_output_and_irq;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Bench state
	// ****
	logic sys_clk;
	logic reset;
	epo_pkg::epo_wb_req_t wb_req;
	epo_pkg::epo_energy_inc_t energy_inc;
	logic [23:0] apparent_power_mag;
	logic [23:0] rms_current_mag;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic wb_ack_o, apparent_accum_en, pulse_out_a_n, pulse_out_b_n, energy_irq;
	logic [7:0] cnt_a, cnt_b, width_a, width_b, base, base_b;
	logic [1:0] sel;
	logic hit;
	logic [15:0] tn [3] = '{16'h0001, 16'h0000, 16'h0005};
	logic [15:0] td [3] = '{16'h0003, 16'h0000, 16'h0003};
	int ti [3] = '{6, 3, 3};
	int te [3] = '{2, 3, 3};
	int errors;
	int cmp_count;

	// Short hold and period limits keep the run brief
	epo_top #(.HOLD_CYC(21'd10), .LONG_CYC(21'd20)) dut (
		.sys_clk(sys_clk), .reset(reset), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .energy_inc(energy_inc),
		.apparent_power_mag(apparent_power_mag), .rms_current_mag(rms_current_mag),
		.other_status_low(8'h00), .other_status_mid(8'h00), .other_status_high(8'h00),
		.apparent_accum_en(apparent_accum_en), .pulse_out_a_n(pulse_out_a_n),
		.pulse_out_b_n(pulse_out_b_n), .energy_irq(energy_irq));
	epo_cal_monitor mon_a (.sys_clk(sys_clk), .reset(reset), .pulse_n(pulse_out_a_n),
		.pulse_cnt(cnt_a), .low_width(width_a));
	epo_cal_monitor mon_b (.sys_clk(sys_clk), .reset(reset), .pulse_n(pulse_out_b_n),
		.pulse_cnt(cnt_b), .low_width(width_b));

	// Clock
	always #50 sys_clk = ~sys_clk;

	// ****
	// Tasks
	// ****
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One classic cycle; held until ack is sampled, then released
	task automatic wb_cycle(input logic wr_en, input logic [7:0] idx, input logic [15:0] wd);
		int n;
		@(posedge sys_clk);
		wb_req.cyc <= 1'b1;
		wb_req.stb <= 1'b1;
		wb_req.we <= wr_en;
		wb_req.sel <= 4'h3;
		wb_req.adr <= {22'h0, idx, 2'b00};
		wb_req.dat <= {16'h0, wd};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
		wb_req.we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
		wb_cycle(1'b1, idx, wd);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		wb_cycle(1'b0, idx, 16'h0000);
		check(name, rd, exp);
	endtask

	// One-cycle energy increment, then a quiet gap
	task automatic pulse_in(input logic [3:0] v, input int gap);
		@(posedge sys_clk);
		energy_inc <= epo_pkg::epo_energy_inc_t'(v);
		@(posedge sys_clk);
		energy_inc <= '0;
		repeat (gap) @(posedge sys_clk);
	endtask

	// ****
	// Main sequence
	// ****
	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		wb_req = '0;
		energy_inc = '0;
		apparent_power_mag = 24'h00_1000;
		rms_current_mag = 24'h00_1000;
		errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		check("idle_a", 32'(pulse_out_a_n), 32'h0000_0001);
		rd_chk("mode_a", `EPO_IDX_MODE_A, 32'h0000_0000);
		rd_chk("unmapped", 8'h01, 32'h0000_0000);
		// Scaling ratios: plain, zero as one, clamped above one
		for (int k = 0; k < 3; k++) begin
			wr(`EPO_IDX_NUM_A, tn[k]);
			wr(`EPO_IDX_DEN_A, td[k]);
			rd_chk("num_a", `EPO_IDX_NUM_A, 32'(tn[k]));
			base = cnt_a;
			repeat (ti[k]) pulse_in(4'h8, 30);
			check("ratio_cnt", 32'(cnt_a - base), 32'(te[k]));
		end
		check("long_w", 32'(width_a), 32'h0000_000A);
		repeat (3) pulse_in(4'h8, 8);
		check("short_w", 32'(width_a), 32'h0000_0005);
		// Every source code, then the shared rms choice
		for (int s = 0; s < 5; s++) begin
			sel = (s == 4) ? 2'd2 : 2'(s);
			wr(`EPO_IDX_MODE_B, {11'h0, s == 4, sel, sel});
			for (int t = 0; t < 4; t++) begin
				base = cnt_a;
				base_b = cnt_b;
				pulse_in(4'h8 >> t, 30);
				hit = (s < 2) ? (t == s) : (t == ((s == 4) ? 3 : 2));
				check("src_a", 32'(cnt_a - base), 32'(hit));
				check("src_b", 32'(cnt_b - base_b), 32'(hit));
			end
		end
		// Output a disabled, b unaffected
		wr(`EPO_IDX_MODE_A, 16'h0010);
		base = cnt_a;
		base_b = cnt_b;
		pulse_in(4'h1, 30);
		check("dis_a", 32'(cnt_a - base), 32'h0000_0000);
		check("dis_b", 32'(cnt_b - base_b), 32'h0000_0001);
		wr(`EPO_IDX_MODE_A, 16'h0000);
		// Flags, masking, write-zero clear, then clear on read
		rd_chk("st_mid", `EPO_IDX_ST_MID, 32'h0000_00C0);
		check("irq_mask", 32'(energy_irq), 32'h0000_0000);
		wr(`EPO_IDX_EN_MID, 16'h0040);
		repeat (2) @(posedge sys_clk);
		check("irq_on", 32'(energy_irq), 32'h0000_0001);
		wr(`EPO_IDX_ST_MID, 16'h0080);
		repeat (2) @(posedge sys_clk);
		check("irq_off", 32'(energy_irq), 32'h0000_0000);
		rd_chk("st_mid", `EPO_IDX_ST_MID, 32'h0000_0080);
		rd_chk("st_mid", `EPO_IDX_ST_MID, 32'h0000_0080);
		wr(`EPO_IDX_PM_EN, 16'h0040);
		rd_chk("st_mid", `EPO_IDX_ST_MID, 32'h0000_0080);
		rd_chk("st_mid", `EPO_IDX_ST_MID, 32'h0000_0000);
		wr(`EPO_IDX_PM_EN, 16'h0000);
		// No-load gating for each threshold code
		for (int m = 1; m < 4; m++) begin
			wr(`EPO_IDX_NL_MODE, 16'(m << 4));
			apparent_power_mag <= 24'h00_0064;
			repeat (3) @(posedge sys_clk);
			check("accum_low", 32'(apparent_accum_en), 32'h0000_0000);
			apparent_power_mag <= 24'h00_1000;
			repeat (3) @(posedge sys_clk);
			check("accum_high", 32'(apparent_accum_en), 32'h0000_0001);
		end
		apparent_power_mag <= 24'h00_0064;
		repeat (3) @(posedge sys_clk);
		rd_chk("st_low", `EPO_IDX_ST_LOW, 32'h0000_0004);
		wr(`EPO_IDX_EN_LOW, 16'h0004);
		repeat (2) @(posedge sys_clk);
		check("irq_creep", 32'(energy_irq), 32'h0000_0001);
		// Rms pulses share the apparent threshold
		rms_current_mag <= 24'h00_0064;
		base = cnt_a;
		pulse_in(4'h1, 30);
		check("rms_low", 32'(cnt_a - base), 32'h0000_0000);
		rms_current_mag <= 24'h00_1000;
		pulse_in(4'h1, 30);
		check("rms_high", 32'(cnt_a - base), 32'h0000_0001);
		wr(`EPO_IDX_NL_MODE, 16'h0000);
		repeat (3) @(posedge sys_clk);
		check("nl_off", 32'(apparent_accum_en), 32'h0000_0001);
		stop_test();
	end

	// Watchdog, well beyond the roughly 1300 cycles the tests need
	initial begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		stop_test();
	end
endmodule // test_energy_pulse_output_and_irq

`default_nettype wire
